// file: design/vrt_pkg.sv
// Summary of operation
// - m variable base/mask pairs, count reported
// - eleven fixed registers, eight type bytes each
// - base bits 7:0 hold range type
// - base field bits 12 up, 4K aligned
// - mask field bits 12 up, width-derived
// - hit when addr&mask equals base&mask
// - mask bit 11 valid gates matching
// - reserved bit write raises protection fault
// - unselected holes get default type
// - mgmt pair faults when capability absent
// - mgmt writes only inside management mode
// - mgmt base: type, base bits 12-31
// - mgmt mask: valid bit 11, mask 12-31
// - in management mode use mgmt type
// - outside mode, with global enable set: uncacheable, drop writes, fill
// - mgmt range overrides fixed and variable
// - optional feature-control enable gates mgmt access
// - only type codes 0,1,4,5,6 legal
// - overlap: uncacheable wins, through beats back
// - reset clears valid flags and enable
package vrt_pkg;
    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_CAP = 8'h00;
    localparam logic [7:0] IDX_DEF = 8'h01;
    localparam logic [7:0] IDX_FIX64 = 8'h02;
    localparam logic [7:0] IDX_FIX_LAST = 8'h0C;
    localparam logic [7:0] IDX_MGMT_BASE = 8'h0D;
    localparam logic [7:0] IDX_MGMT_MASK = 8'h0E;
    localparam logic [7:0] IDX_VAR_FIRST = 8'h10;
    // ----------------------------------------
    // fields and sizes
    // ----------------------------------------
    localparam int PA_DEFAULT = 36;
    localparam int NPAIR_DEFAULT = 8;
    localparam int FIX_ENTRIES = 11;
    localparam logic [3:0] FIX16_FIRST = 4'h1;
    localparam logic [3:0] FIX4K_FIRST = 4'h3;
    localparam int VALID_BIT = 11;
    localparam int FIELD_LSB = 12;
    localparam int MGMT_TOP = 32;
    localparam int LOW_MEG_BITS = 20;
    localparam int CAP_FIX_BIT = 8;
    localparam int CAP_WC_BIT = 10;
    localparam int CAP_MGMT_BIT = 11;
    localparam int DEF_FE_BIT = 10;
    localparam int DEF_E_BIT = 11;
    localparam int RESP_LATENCY = 2;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // ----------------------------------------
    // memory type codes
    // ----------------------------------------
    localparam logic [7:0] T_UC = 8'h00;
    localparam logic [7:0] T_WC = 8'h01;
    localparam logic [7:0] T_WT = 8'h04;
    localparam logic [7:0] T_WP = 8'h05;
    localparam logic [7:0] T_WB = 8'h06;

    function automatic logic type_ok(input logic [7:0] t);
        return (t == T_UC) || (t == T_WC) || (t == T_WT) || (t == T_WP) || (t == T_WB);
    endfunction
endpackage

// file: design/vrt_match_if.sv
`timescale 1ns/1ps
interface vrt_match_if #(parameter int PA = 36);
    logic [PA-1:0] addr;
    logic [PA-13:0] base;
    logic [PA-13:0] mask;
    logic valid;
    logic hit;
    modport core (output addr, output base, output mask, output valid, input hit);
    modport matcher (input addr, input base, input mask, input valid, output hit);
endinterface

// file: design/vrt_range_match.sv
`timescale 1ns/1ps
module vrt_range_match #(
    parameter int PA = 36
) (
    vrt_match_if.matcher port
);
    // a zero mask bit drops out of the compare, so a hole in the mask matches either address value there
    assign port.hit = port.valid && ((port.addr[PA-1:12] & port.mask) == (port.base & port.mask));
endmodule

// file: design/vrt_fix_mem.sv
`timescale 1ns/1ps
module vrt_fix_mem #(
    parameter int W = 64,
    parameter int DEPTH = 11,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [W-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [W-1:0] rdata_b
);
    // contents are undefined after reset, software clears them first
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule

// file: design/vrt_range_guard.sv
`timescale 1ns/1ps
module vrt_range_guard #(
    parameter int PA = vrt_pkg::PA_DEFAULT,
    parameter int NPAIR = vrt_pkg::NPAIR_DEFAULT,
    parameter bit MGMT_SUPPORTED = 1'b1,
    parameter bit MGMT_NEEDS_FEATURE = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [7:0] reg_index,
    input wire logic [63:0] reg_wdata,
    output logic reg_ack,
    output logic reg_fault,
    output logic [63:0] reg_rdata,
    input wire logic mgmt_mode,
    input wire logic mgmt_feature_enable,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [PA-1:0] acc_addr,
    output logic acc_done,
    output logic [7:0] acc_type,
    output logic acc_drop_write,
    output logic acc_fill_read
);
    localparam int FW = PA - vrt_pkg::FIELD_LSB;
    localparam int MW = vrt_pkg::MGMT_TOP - vrt_pkg::FIELD_LSB;

    typedef struct packed {
        logic [NPAIR-1:0][FW-1:0] vbase;
        logic [NPAIR-1:0][7:0] vtype;
        logic [NPAIR-1:0][FW-1:0] vmask;
        logic [NPAIR-1:0] vvalid;
        logic [MW-1:0] mbase;
        logic [7:0] mtype;
        logic [MW-1:0] mmask;
        logic mvalid;
        logic [7:0] def_type;
        logic fix_en;
        logic glob_en;
        logic r1_valid;
        logic r1_fix;
        logic r1_fault;
        logic [63:0] r1_data;
        logic ack;
        logic fault;
        logic [63:0] rdata;
        logic a1_valid;
        logic a1_write;
        logic a1_fix;
        logic [2:0] a1_byte;
        logic [7:0] a1_type;
        logic a1_guard;
        logic done;
        logic [7:0] atype;
        logic drop;
        logic fill;
    } vrt_state_s;

    vrt_state_s s_q;
    vrt_state_s s_d;
    logic [NPAIR-1:0] hit_c;
    logic [63:0] mem_a;
    logic [63:0] mem_b;
    logic mem_we;
    logic [3:0] fix_raddr;
    logic [3:0] fix_entry_c;
    logic [2:0] fix_byte_c;
    logic is_var_c;
    logic var_is_mask_c;
    logic is_fix_c;
    logic is_mgmt_c;
    logic mgmt_hit_c;
    logic low_meg_c;
    logic [7:0] var_off_c;

    // ----------------------------------------
    // per-pair matchers
    // ----------------------------------------
    for (genvar g = 0; g < NPAIR; g++) begin : g_pair
        vrt_match_if #(.PA(PA)) m_if ();
        assign m_if.addr = acc_addr;
        assign m_if.base = s_q.vbase[g];
        assign m_if.mask = s_q.vmask[g];
        assign m_if.valid = s_q.vvalid[g];
        vrt_range_match #(.PA(PA)) u_match (.port(m_if.matcher));
        assign hit_c[g] = m_if.hit;
    end

    // ----------------------------------------
    // fixed-range storage
    // ----------------------------------------
    assign fix_raddr = 4'(reg_index - vrt_pkg::IDX_FIX64);

    vrt_fix_mem #(.W(64), .DEPTH(vrt_pkg::FIX_ENTRIES), .AW(4)) u_fix (
        .clk(clk),
        .we(mem_we),
        .waddr(fix_raddr),
        .wdata(reg_wdata),
        .raddr_a(fix_raddr),
        .rdata_a(mem_a),
        .raddr_b(fix_entry_c),
        .rdata_b(mem_b)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    always_comb begin
        // lowest sub-range sits in the lowest byte of each register
        if (!acc_addr[19]) begin
            fix_entry_c = 4'h0;
            fix_byte_c = acc_addr[18:16];
        end else if (!acc_addr[18]) begin
            fix_entry_c = vrt_pkg::FIX16_FIRST + {3'h0, acc_addr[17]};
            fix_byte_c = acc_addr[16:14];
        end else begin
            fix_entry_c = vrt_pkg::FIX4K_FIRST + {1'h0, acc_addr[17:15]};
            fix_byte_c = acc_addr[14:12];
        end
    end

    assign low_meg_c = (acc_addr[PA-1:vrt_pkg::LOW_MEG_BITS] == '0) && s_q.fix_en;
    // the mgmt region lies below 4 GB, so any higher address bit is a miss
    assign mgmt_hit_c = s_q.mvalid && (acc_addr[PA-1:vrt_pkg::MGMT_TOP] == '0)
        && ((acc_addr[vrt_pkg::MGMT_TOP-1:12] & s_q.mmask) == (s_q.mbase & s_q.mmask));
    assign var_off_c = reg_index - vrt_pkg::IDX_VAR_FIRST;
    assign is_var_c = (reg_index >= vrt_pkg::IDX_VAR_FIRST) && (var_off_c < 8'(2 * NPAIR));
    assign var_is_mask_c = var_off_c[0];
    assign is_fix_c = (reg_index >= vrt_pkg::IDX_FIX64) && (reg_index <= vrt_pkg::IDX_FIX_LAST);
    assign is_mgmt_c = (reg_index == vrt_pkg::IDX_MGMT_BASE) || (reg_index == vrt_pkg::IDX_MGMT_MASK);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic flt;
        logic [63:0] rd;
        logic mg_ok;
        int p;
        logic any_uc;
        logic any_wt;
        logic any_wb;
        logic same;
        logic any_hit;
        logic [7:0] first;
        logic [7:0] vt;
        flt = 1'b0;
        rd = '0;
        p = 0;
        any_uc = 1'b0;
        any_wt = 1'b0;
        any_wb = 1'b0;
        same = 1'b1;
        any_hit = 1'b0;
        first = vrt_pkg::T_UC;
        vt = vrt_pkg::T_UC;
        mem_we = 1'b0;
        s_d = s_q;
        mg_ok = MGMT_SUPPORTED && (!MGMT_NEEDS_FEATURE || mgmt_feature_enable);

        // register access, answered two edges later
        if (is_var_c) begin
            p = int'(var_off_c[7:1]);
            if (!var_is_mask_c) begin
                rd[PA-1:12] = s_q.vbase[p];
                rd[7:0] = s_q.vtype[p];
                flt = (reg_wdata[11:8] != 4'h0) || (reg_wdata[63:PA] != '0) || !vrt_pkg::type_ok(reg_wdata[7:0]);
                if (reg_req && reg_write && !flt) begin
                    s_d.vbase[p] = reg_wdata[PA-1:12];
                    s_d.vtype[p] = reg_wdata[7:0];
                end
            end else begin
                rd[PA-1:12] = s_q.vmask[p];
                rd[vrt_pkg::VALID_BIT] = s_q.vvalid[p];
                flt = (reg_wdata[10:0] != 11'h000) || (reg_wdata[63:PA] != '0);
                if (reg_req && reg_write && !flt) begin
                    s_d.vmask[p] = reg_wdata[PA-1:12];
                    s_d.vvalid[p] = reg_wdata[vrt_pkg::VALID_BIT];
                end
            end
        end else if (is_fix_c) begin
            for (int b = 0; b < 8; b++) begin
                if (!vrt_pkg::type_ok(reg_wdata[8*b +: 8])) begin
                    flt = 1'b1;
                end
            end
            mem_we = reg_req && reg_write && !flt;
        end else if (is_mgmt_c) begin
            if (reg_index == vrt_pkg::IDX_MGMT_BASE) begin
                rd[vrt_pkg::MGMT_TOP-1:12] = s_q.mbase;
                rd[7:0] = s_q.mtype;
                flt = (reg_wdata[63:vrt_pkg::MGMT_TOP] != '0) || (reg_wdata[11:8] != 4'h0)
                    || !vrt_pkg::type_ok(reg_wdata[7:0]);
            end else begin
                rd[vrt_pkg::MGMT_TOP-1:12] = s_q.mmask;
                rd[vrt_pkg::VALID_BIT] = s_q.mvalid;
                flt = (reg_wdata[63:vrt_pkg::MGMT_TOP] != '0) || (reg_wdata[10:0] != 11'h000);
            end
            if (!reg_write) begin
                flt = 1'b0;
            end else if (!mgmt_mode) begin
                flt = 1'b1;
            end
            if (!mg_ok) begin
                flt = 1'b1;
            end
            if (reg_req && reg_write && !flt) begin
                if (reg_index == vrt_pkg::IDX_MGMT_BASE) begin
                    s_d.mbase = reg_wdata[vrt_pkg::MGMT_TOP-1:12];
                    s_d.mtype = reg_wdata[7:0];
                end else begin
                    s_d.mmask = reg_wdata[vrt_pkg::MGMT_TOP-1:12];
                    s_d.mvalid = reg_wdata[vrt_pkg::VALID_BIT];
                end
            end
        end else if (reg_index == vrt_pkg::IDX_CAP) begin
            rd[7:0] = 8'(NPAIR);
            rd[vrt_pkg::CAP_FIX_BIT] = 1'b1;
            rd[vrt_pkg::CAP_WC_BIT] = 1'b1;
            rd[vrt_pkg::CAP_MGMT_BIT] = MGMT_SUPPORTED;
            flt = reg_write;
        end else if (reg_index == vrt_pkg::IDX_DEF) begin
            rd[7:0] = s_q.def_type;
            rd[vrt_pkg::DEF_FE_BIT] = s_q.fix_en;
            rd[vrt_pkg::DEF_E_BIT] = s_q.glob_en;
            flt = (reg_wdata[63:12] != '0) || (reg_wdata[9:8] != 2'h0) || !vrt_pkg::type_ok(reg_wdata[7:0]);
            if (reg_req && reg_write && !flt) begin
                s_d.def_type = reg_wdata[7:0];
                s_d.fix_en = reg_wdata[vrt_pkg::DEF_FE_BIT];
                s_d.glob_en = reg_wdata[vrt_pkg::DEF_E_BIT];
            end
        end else begin
            flt = 1'b1;
        end
        // a read never faults on the reserved-bit checks, only on mgmt access rights or an unused index
        if (!reg_write && !is_mgmt_c && (is_var_c || is_fix_c || reg_index == vrt_pkg::IDX_CAP
            || reg_index == vrt_pkg::IDX_DEF)) begin
            flt = 1'b0;
        end
        s_d.r1_valid = reg_req;
        s_d.r1_fix = is_fix_c && !reg_write;
        s_d.r1_fault = reg_req && flt;
        s_d.r1_data = reg_write ? '0 : rd;
        s_d.ack = s_q.r1_valid;
        s_d.fault = s_q.r1_fault;
        s_d.rdata = (!s_q.r1_valid || s_q.r1_fault) ? '0 : (s_q.r1_fix ? mem_a : s_q.r1_data);

        // variable combine; undefined mixes resolve to uncacheable
        for (int i = 0; i < NPAIR; i++) begin
            if (hit_c[i]) begin
                if (any_hit && s_q.vtype[i] != first) begin
                    same = 1'b0;
                end
                if (!any_hit) begin
                    first = s_q.vtype[i];
                end
                any_hit = 1'b1;
                any_uc = any_uc || (s_q.vtype[i] == vrt_pkg::T_UC);
                any_wt = any_wt || (s_q.vtype[i] == vrt_pkg::T_WT);
                any_wb = any_wb || (s_q.vtype[i] == vrt_pkg::T_WB);
            end
        end
        if (!any_hit) begin
            vt = s_q.def_type;
        end else if (any_uc) begin
            vt = vrt_pkg::T_UC;
        end else if (same) begin
            vt = first;
        end else if (any_wt && any_wb) begin
            vt = vrt_pkg::T_WT;
        end else begin
            vt = vrt_pkg::T_UC;
        end

        // access lookup, stage one
        s_d.a1_valid = acc_valid;
        s_d.a1_write = acc_write;
        s_d.a1_fix = 1'b0;
        s_d.a1_byte = fix_byte_c;
        s_d.a1_guard = 1'b0;
        if (!s_q.glob_en) begin
            s_d.a1_type = vrt_pkg::T_UC;
        end else if (mgmt_hit_c) begin
            s_d.a1_type = mgmt_mode ? s_q.mtype : vrt_pkg::T_UC;
            s_d.a1_guard = !mgmt_mode;
        end else if (low_meg_c) begin
            s_d.a1_type = vrt_pkg::T_UC;
            s_d.a1_fix = 1'b1;
        end else begin
            s_d.a1_type = vt;
        end
        // stage two drives the ports
        s_d.done = s_q.a1_valid;
        s_d.atype = s_q.a1_fix ? mem_b[{s_q.a1_byte, 3'h0} +: 8] : s_q.a1_type;
        s_d.drop = s_q.a1_valid && s_q.a1_guard && s_q.a1_write;
        s_d.fill = s_q.a1_valid && s_q.a1_guard && !s_q.a1_write;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_ack = s_q.ack;
    assign reg_fault = s_q.fault;
    assign reg_rdata = s_q.rdata;
    assign acc_done = s_q.done;
    assign acc_type = s_q.atype;
    assign acc_drop_write = s_q.drop;
    assign acc_fill_read = s_q.fill;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // same permission term as the next-state logic, visible to the checks
    logic mg_ok_w;
    assign mg_ok_w = MGMT_SUPPORTED && (!MGMT_NEEDS_FEATURE || mgmt_feature_enable);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_base_resv_fault: assert property (reg_req && reg_write && is_var_c && !var_is_mask_c
        && reg_wdata[11:8] != 4'h0 |-> ##2 reg_ack && reg_fault) else $error("reserved base write not faulted");
    a_mask_resv_fault: assert property (reg_req && reg_write && is_var_c && var_is_mask_c
        && reg_wdata[63:PA] != '0 |-> ##2 reg_fault) else $error("reserved mask write not faulted");
    a_fix_type_fault: assert property (reg_req && reg_write && is_fix_c && !vrt_pkg::type_ok(reg_wdata[7:0])
        |-> !mem_we ##2 reg_ack && reg_fault) else $error("bad fixed type accepted");
    a_mgmt_unsup: assert property (reg_req && is_mgmt_c && !mg_ok_w |-> ##2 reg_fault)
        else $error("mgmt access without support not faulted");
    a_mgmt_out_mode: assert property (reg_req && reg_write && is_mgmt_c && !mgmt_mode
        |=> $stable(s_q.mbase) && $stable(s_q.mmask) ##1 reg_fault) else $error("mgmt write outside mode");
    a_mgmt_inside: assert property (acc_valid && s_q.glob_en && mgmt_hit_c && mgmt_mode
        |-> ##2 acc_type == $past(s_q.mtype, 2) && !acc_drop_write) else $error("mgmt type not used");
    a_mgmt_guard: assert property (acc_valid && acc_write && s_q.glob_en && mgmt_hit_c && !mgmt_mode
        |-> ##2 acc_done && acc_type == vrt_pkg::T_UC && acc_drop_write) else $error("guarded write passed");
    a_disabled_uc: assert property (acc_valid && !s_q.glob_en |-> ##2 acc_done && acc_type == vrt_pkg::T_UC)
        else $error("disabled lookup not uncacheable");
endmodule

// file: verification/vrt_core_model.sv
`timescale 1ns/1ps
module vrt_core_model #(
    parameter int PA = 36
) (
    input wire logic clk,
    output logic reg_req,
    output logic reg_write,
    output logic [7:0] reg_index,
    output logic [63:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic reg_fault,
    input wire logic [63:0] reg_rdata,
    output logic mgmt_mode,
    output logic mgmt_feature_enable,
    output logic acc_valid,
    output logic acc_write,
    output logic [PA-1:0] acc_addr,
    input wire logic acc_done,
    input wire logic [7:0] acc_type,
    input wire logic acc_drop_write,
    input wire logic acc_fill_read
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial begin
        reg_req = 1'b0;
        reg_write = 1'b0;
        reg_index = 8'h00;
        reg_wdata = 64'h0;
        mgmt_mode = 1'b0;
        mgmt_feature_enable = 1'b1;
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_addr = '0;
    end

    // ----------------------------------------
    // register access, answer 2 edges after take
    // ----------------------------------------
    task automatic reg_op(input logic wr, input logic [7:0] idx, input logic [63:0] wd,
                          output logic [63:0] rd, output logic flt, output logic ack);
        @(posedge clk);
        #1;
        reg_req = 1'b1;
        reg_write = wr;
        reg_index = idx;
        reg_wdata = wd;
        @(posedge clk);
        #1;
        reg_req = 1'b0;
        // released qualifiers change so a stale value is never mistaken for held data
        reg_index = ~idx;
        reg_wdata = ~wd;
        // the answer stands from the second edge after take until the third
        @(posedge clk);
        #1;
        rd = reg_rdata;
        flt = reg_fault;
        ack = reg_ack;
    endtask

    // software looks at the capability before touching the mgmt pair
    task automatic probe_cap(output logic present);
        logic [63:0] rd;
        logic f;
        logic a;
        reg_op(1'b0, 8'h00, 64'h0, rd, f, a);
        present = a & ~f & rd[vrt_pkg::CAP_MGMT_BIT];
    endtask

    task automatic set_mode(input logic m);
        @(posedge clk);
        #1;
        mgmt_mode = m;
    endtask

    // ----------------------------------------
    // type lookup, answer 2 edges after take
    // ----------------------------------------
    task automatic lookup(input logic wr, input logic [PA-1:0] a, output logic [7:0] t,
                          output logic [1:0] df, output logic dn);
        @(posedge clk);
        #1;
        acc_valid = 1'b1;
        acc_write = wr;
        acc_addr = a;
        @(posedge clk);
        #1;
        acc_valid = 1'b0;
        acc_write = ~wr;
        acc_addr = ~a;
        @(posedge clk);
        #1;
        t = acc_type;
        df = {acc_drop_write, acc_fill_read};
        dn = acc_done;
    endtask
endmodule

// file: verification/vrt_range_guard_bench.sv
`timescale 1ns/1ps
module vrt_range_guard_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_req, reg_write, reg_ack, reg_fault, mgmt_mode, mgmt_feature_enable;
    logic [7:0] reg_index;
    logic [63:0] reg_wdata, reg_rdata;
    logic acc_valid, acc_write, acc_done, acc_drop_write, acc_fill_read;
    logic [35:0] acc_addr;
    logic [7:0] acc_type;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    logic mp;
    // fixed-range probe points and the type byte each should pick
    logic [35:0] fx_addr [8] = '{36'h00000, 36'h10000, 36'h7FFFF, 36'hC1000, 36'hC0FFF, 36'hFFFFF,
                                 36'h80000, 36'h84000};
    logic [7:0] fx_type [8] = '{8'h04, 8'h05, 8'h06, 8'h01, 8'h00, 8'h06, 8'h04, 8'h00};

    always #2 clk = ~clk;

    vrt_range_guard vrt_range_guard_inst (.clk(clk), .resetn(resetn), .reg_req(reg_req),
        .reg_write(reg_write), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_fault(reg_fault), .reg_rdata(reg_rdata), .mgmt_mode(mgmt_mode),
        .mgmt_feature_enable(mgmt_feature_enable), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_done(acc_done), .acc_type(acc_type),
        .acc_drop_write(acc_drop_write), .acc_fill_read(acc_fill_read));

    vrt_core_model #(.PA(36)) vrt_core_model_inst (.clk(clk), .reg_req(reg_req), .reg_write(reg_write),
        .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_fault(reg_fault),
        .reg_rdata(reg_rdata), .mgmt_mode(mgmt_mode), .mgmt_feature_enable(mgmt_feature_enable),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .acc_done(acc_done),
        .acc_type(acc_type), .acc_drop_write(acc_drop_write), .acc_fill_read(acc_fill_read));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    // ----------------------------------------
    // access helpers
    // ----------------------------------------
    task automatic wreg(input logic [7:0] idx, input logic [63:0] d, input logic ef);
        logic [63:0] rd;
        logic f;
        logic a;
        vrt_core_model_inst.reg_op(1'b1, idx, d, rd, f, a);
        check({63'h0, a}, 64'h1);
        check({63'h0, f}, {63'h0, ef});
    endtask

    // only bits set in msk are compared; undefined reset bits stay out
    task automatic rreg(input logic [7:0] idx, input logic [63:0] exp, input logic [63:0] msk);
        logic [63:0] rd;
        logic f;
        logic a;
        vrt_core_model_inst.reg_op(1'b0, idx, 64'h0, rd, f, a);
        check({62'h0, a, f}, 64'h2);
        check(rd & msk, exp);
    endtask

    task automatic lk(input logic wr, input logic [35:0] ad, input logic [7:0] et, input logic [1:0] edf);
        logic [7:0] t;
        logic [1:0] df;
        logic dn;
        vrt_core_model_inst.lookup(wr, ad, t, df, dn);
        check({53'h0, dn, df, t}, {53'h0, 1'b1, edf, et});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        lk(1'b0, 36'h000200000, vrt_pkg::T_UC, 2'b00);
        rreg(8'h11, 64'h0, 64'h800);
        rreg(8'h01, 64'h0, 64'h800);
        rreg(8'h00, 64'hD08, 64'hFFFFFFFFFFFFFFFF);
        wreg(8'h10, 64'h000200006, 1'b0);
        wreg(8'h11, 64'hFFFE00800, 1'b0);
        rreg(8'h10, 64'h000200006, 64'hFFFFFFFFFFFFFFFF);
        rreg(8'h11, 64'hFFFE00800, 64'hFFFFFFFFFFFFFFFF);
        wreg(8'h01, 64'h804, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_WB, 2'b00);
        lk(1'b0, 36'h0003FFFFF, vrt_pkg::T_WB, 2'b00);
        lk(1'b0, 36'h000400000, vrt_pkg::T_WT, 2'b00);
        lk(1'b0, 36'h0001FFFFF, vrt_pkg::T_WT, 2'b00);
        wreg(8'h10, 64'h000200106, 1'b1);
        wreg(8'h11, 64'h1FFFE00800, 1'b1);
        wreg(8'h11, 64'hFFFE00801, 1'b1);
        rreg(8'h10, 64'h000200006, 64'hFFFFFFFFFFFFFFFF);
        for (int t = 0; t < 8; t++) begin
            wreg(8'h12, 64'(t), !(t == 0 || t == 1 || (t >= 4 && t <= 6)));
        end
        wreg(8'h12, 64'h000200000, 1'b0);
        wreg(8'h13, 64'hFFFE00800, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_UC, 2'b00);
        wreg(8'h12, 64'h000200004, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_WT, 2'b00);
        wreg(8'h12, 64'h000200006, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_WB, 2'b00);
        wreg(8'h11, 64'hFFFE00000, 1'b0);
        wreg(8'h13, 64'hFFFE00000, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_WT, 2'b00);
        wreg(8'h10, 64'h000000006, 1'b0);
        wreg(8'h11, 64'hFFFDFF800, 1'b0);
        lk(1'b0, 36'h000200000, vrt_pkg::T_WB, 2'b00);
        lk(1'b0, 36'h000001000, vrt_pkg::T_WT, 2'b00);
        wreg(8'h02, 64'h0605040100060504, 1'b0);
        wreg(8'h05, 64'h0000000000000100, 1'b0);
        wreg(8'h0C, 64'h0600000000000000, 1'b0);
        wreg(8'h03, 64'h0000000000000004, 1'b0);
        wreg(8'h02, 64'h0000000000000003, 1'b1);
        wreg(8'h01, 64'hC04, 1'b0);
        for (int i = 0; i < 8; i++) begin
            lk(1'b0, fx_addr[i], fx_type[i], 2'b00);
        end
        vrt_core_model_inst.probe_cap(mp);
        check({63'h0, mp}, 64'h1);
        wreg(8'h0D, 64'h010000006, 1'b1);
        vrt_core_model_inst.set_mode(1'b1);
        wreg(8'h0D, 64'h010000006, 1'b0);
        wreg(8'h0E, 64'h0FFF00800, 1'b0);
        wreg(8'h0D, 64'h110000006, 1'b1);
        rreg(8'h0E, 64'h0FFF00800, 64'hFFFFFFFFFFFFFFFF);
        wreg(8'h14, 64'h010000004, 1'b0);
        wreg(8'h15, 64'hFF0000800, 1'b0);
        lk(1'b0, 36'h0100FFFFF, vrt_pkg::T_WB, 2'b00);
        lk(1'b0, 36'h010100000, vrt_pkg::T_WT, 2'b00);
        lk(1'b0, 36'h110000000, vrt_pkg::T_WT, 2'b00);
        vrt_core_model_inst.set_mode(1'b0);
        lk(1'b0, 36'h010000000, vrt_pkg::T_UC, 2'b01);
        lk(1'b1, 36'h010000000, vrt_pkg::T_UC, 2'b10);
        wreg(8'h0E, 64'h0FFF00000, 1'b1);
        results();
    end
endmodule
